// ---- include/lc_pkg.sv ----
// constants and types for the configurable logic cell
// assumes a classic wishbone slave with 32-bit data and byte addressing
package lc_pkg;

  // bus geometry
  localparam int LC_ADR_W = 4;
  localparam int LC_DAT_W = 32;
  localparam int LC_SEL_W = 4;

  // register byte offsets
  localparam logic [LC_ADR_W-1:0] LC_OFF_LUT_F = 4'h0;
  localparam logic [LC_ADR_W-1:0] LC_OFF_LUT_G = 4'h4;
  localparam logic [LC_ADR_W-1:0] LC_OFF_CTRL = 4'h8;
  localparam logic [LC_ADR_W-1:0] LC_OFF_STATUS = 4'hC;

  // widths
  localparam int LC_LUT_BITS = 16;
  localparam int LC_CTRL_BITS = 16;
  localparam int LC_NUM_IN = 5;

  // control register field positions
  localparam int LC_CTRL_MODE_LSB = 0;
  localparam int LC_CTRL_F_USE_E = 2;
  localparam int LC_CTRL_G_USE_E = 3;
  localparam int LC_CTRL_F_B_FF = 4;
  localparam int LC_CTRL_F_C_FF = 5;
  localparam int LC_CTRL_G_B_FF = 6;
  localparam int LC_CTRL_G_C_FF = 7;
  localparam int LC_CTRL_OUTX_LSB = 8;
  localparam int LC_CTRL_OUTY_LSB = 10;
  localparam int LC_CTRL_FFX_LSB = 12;
  localparam int LC_CTRL_FFY_LSB = 14;

  // status register field positions
  localparam int LC_STAT_FFX = 0;
  localparam int LC_STAT_FFY = 1;
  localparam int LC_STAT_CELLX = 2;
  localparam int LC_STAT_CELLY = 3;
  localparam int LC_STAT_IN_LSB = 4;

  // reset values
  localparam logic [LC_LUT_BITS-1:0] LC_LUT_RST = 16'h0000;
  localparam logic [LC_CTRL_BITS-1:0] LC_CTRL_RST = 16'h0000;

  // function generator modes
  typedef enum logic [1:0] {
    LC_DUAL_LUT_MODE = 2'b00,
    LC_MERGED_LUT_MODE = 2'b01,
    LC_MUXED_LUT_MODE = 2'b10
  } lc_mode_e;

  // cell output source
  typedef enum logic [1:0] {
    LC_OUT_FN_F = 2'b00,
    LC_OUT_FN_G = 2'b01,
    LC_OUT_FF_X = 2'b10,
    LC_OUT_FF_Y = 2'b11
  } lc_out_src_e;

  // flip-flop data source
  typedef enum logic [1:0] {
    LC_FFD_FN_F = 2'b00,
    LC_FFD_FN_G = 2'b01,
    LC_FFD_DIRECT = 2'b10,
    LC_FFD_DIRECT_ALT = 2'b11
  } lc_ffd_src_e;

endpackage

// ---- rtl/lc_ff_pair.sv ----
// the two storage flip-flops of the logic cell
// assumes the reset arrives asynchronously and is active high
`timescale 1ns/1ps
`default_nettype none
module lc_ff_pair #(
  parameter int N = 2
) (
  // shared clock and asynchronous clear
  input wire logic clk_i,
  input wire logic clear_i,
  // shared clock gate
  input wire logic ff_clock_gate_i,
  // data in, registered out
  input wire logic [N-1:0] d_i,
  output logic [N-1:0] q_o
);

  // edge-triggered only; clear first, then enable
  always_ff @(posedge clk_i or posedge clear_i)
  begin
    if (clear_i)
    begin
      q_o <= '0;
    end
    else if (ff_clock_gate_i)
    begin
      q_o <= d_i;
    end
    else
    begin
      q_o <= q_o;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/lc_logic_cell.sv ----
// logic cell top: function generator, two flip-flops, output selection,
// configuration and status registers behind a classic wishbone slave
// assumes logic pins and clock gate are asynchronous to clk_i
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lc_logic_cell
  import lc_pkg::*;
(
  // clock and bus reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lc_pkg::LC_ADR_W-1:0] wb_adr_i,
  input wire logic [lc_pkg::LC_SEL_W-1:0] wb_sel_i,
  input wire logic [lc_pkg::LC_DAT_W-1:0] wb_dat_i,
  output logic [lc_pkg::LC_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // cell logic inputs a..e in bits 0..4
  input wire logic [lc_pkg::LC_NUM_IN-1:0] logic_in_i,
  // direct flip-flop data input
  input wire logic direct_data_i,
  // shared flip-flop clock gate
  input wire logic ff_clock_gate_i,
  // flip-flop asynchronous clear
  input wire logic cell_clear_i,
  // cell outputs
  output logic cell_x_o,
  output logic cell_y_o,
  output logic first_ff_out_o,
  output logic second_ff_out_o
);

  // all clocked state of the top
  typedef struct packed {
    logic [LC_NUM_IN-1:0] in_meta;
    logic [LC_NUM_IN-1:0] in_sync;
    logic din_meta;
    logic din_sync;
    logic gate_meta;
    logic gate_sync;
    logic [LC_LUT_BITS-1:0] lut_f;
    logic [LC_LUT_BITS-1:0] lut_g;
    logic [LC_CTRL_BITS-1:0] ctrl;
    logic ack;
    logic [LC_DAT_W-1:0] rdata;
    logic cell_x;
    logic cell_y;
  } lc_state_s;

  lc_state_s state;
  lc_state_s next_state;

  // decoded configuration
  lc_mode_e mode;
  logic f_use_e;
  logic g_use_e;
  logic f_b_ff;
  logic f_c_ff;
  logic g_b_ff;
  logic g_c_ff;
  lc_out_src_e out_x_src;
  lc_out_src_e out_y_src;
  lc_ffd_src_e ffx_src;
  lc_ffd_src_e ffy_src;

  // synchronised logic inputs
  logic in_a;
  logic in_b;
  logic in_c;
  logic in_d;
  logic in_e;

  // flip-flop feedback
  logic [1:0] ff_q;
  logic [1:0] ff_d;

  // table addresses and results
  logic [3:0] f_addr;
  logic [3:0] g_addr;
  logic f_res;
  logic g_res;
  logic fn_f;
  logic fn_g;

  // bus helpers
  logic bus_req;
  logic bus_take;
  logic [LC_DAT_W-1:0] status_word;

  // byte-lane merge for a write
  function automatic logic [LC_DAT_W-1:0] lc_merge(
    input logic [LC_DAT_W-1:0] old_val,
    input logic [LC_DAT_W-1:0] new_val,
    input logic [LC_SEL_W-1:0] sel
  );
    logic [LC_DAT_W-1:0] res;
    res = old_val;
    for (int i = 0; i < LC_SEL_W; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // control register field decode; illegal mode code falls back to dual
  always_comb
  begin
    unique case (state.ctrl[LC_CTRL_MODE_LSB +: 2])
      2'b01: mode = LC_MERGED_LUT_MODE;
      2'b10: mode = LC_MUXED_LUT_MODE;
      default: mode = LC_DUAL_LUT_MODE;
    endcase
    f_use_e = state.ctrl[LC_CTRL_F_USE_E];
    g_use_e = state.ctrl[LC_CTRL_G_USE_E];
    out_x_src = lc_out_src_e'(state.ctrl[LC_CTRL_OUTX_LSB +: 2]);
    out_y_src = lc_out_src_e'(state.ctrl[LC_CTRL_OUTY_LSB +: 2]);
    ffx_src = lc_ffd_src_e'(state.ctrl[LC_CTRL_FFX_LSB +: 2]);
    ffy_src = lc_ffd_src_e'(state.ctrl[LC_CTRL_FFY_LSB +: 2]);
  end

  // feedback substitution choices per table
  always_comb
  begin
    f_b_ff = state.ctrl[LC_CTRL_F_B_FF];
    f_c_ff = state.ctrl[LC_CTRL_F_C_FF];
    if (mode == LC_MERGED_LUT_MODE)
    begin
      g_b_ff = state.ctrl[LC_CTRL_F_B_FF];
      g_c_ff = state.ctrl[LC_CTRL_F_C_FF];
    end
    else
    begin
      g_b_ff = state.ctrl[LC_CTRL_G_B_FF];
      g_c_ff = state.ctrl[LC_CTRL_G_C_FF];
    end
  end

  // synchronised pins as named inputs
  always_comb
  begin
    in_a = state.in_sync[0];
    in_b = state.in_sync[1];
    in_c = state.in_sync[2];
    in_d = state.in_sync[3];
    in_e = state.in_sync[4];
  end

  // table addresses: a in bit 0, fourth variable in bit 3
  always_comb
  begin
    f_addr[0] = in_a;
    f_addr[1] = f_b_ff ? ff_q[0] : in_b;
    f_addr[2] = f_c_ff ? ff_q[1] : in_c;
    g_addr[0] = in_a;
    g_addr[1] = g_b_ff ? ff_q[0] : in_b;
    g_addr[2] = g_c_ff ? ff_q[1] : in_c;
    if (mode == LC_DUAL_LUT_MODE)
    begin
      f_addr[3] = f_use_e ? in_e : in_d;
      g_addr[3] = g_use_e ? in_e : in_d;
    end
    else
    begin
      f_addr[3] = in_d;
      g_addr[3] = in_d;
    end
  end

  // the two look-up tables
  lc_lut4 #(
    .SEL_W(4)
  ) u_lut_f (
    .table_i(state.lut_f),
    .sel_i(f_addr),
    .out_o(f_res)
  );

  lc_lut4 #(
    .SEL_W(4)
  ) u_lut_g (
    .table_i(state.lut_g),
    .sel_i(g_addr),
    .out_o(g_res)
  );

  // combine the tables according to mode
  always_comb
  begin
    unique case (mode)
      LC_DUAL_LUT_MODE:
      begin
        fn_f = f_res;
        fn_g = g_res;
      end
      LC_MERGED_LUT_MODE:
      begin
        fn_f = in_e ? g_res : f_res;
        fn_g = fn_f;
      end
      LC_MUXED_LUT_MODE:
      begin
        fn_f = in_e ? g_res : f_res;
        fn_g = fn_f;
      end
    endcase
  end

  // flip-flop data selection
  always_comb
  begin
    unique case (ffx_src)
      LC_FFD_FN_F: ff_d[0] = fn_f;
      LC_FFD_FN_G: ff_d[0] = fn_g;
      LC_FFD_DIRECT: ff_d[0] = state.din_sync;
      LC_FFD_DIRECT_ALT: ff_d[0] = state.din_sync;
    endcase
    unique case (ffy_src)
      LC_FFD_FN_F: ff_d[1] = fn_f;
      LC_FFD_FN_G: ff_d[1] = fn_g;
      LC_FFD_DIRECT: ff_d[1] = state.din_sync;
      LC_FFD_DIRECT_ALT: ff_d[1] = state.din_sync;
    endcase
  end

  // the cell flip-flops; asynchronous clear only, both cleared to zero
  lc_ff_pair #(
    .N(2)
  ) u_ff (
    .clk_i(clk_i),
    .clear_i(cell_clear_i),
    .ff_clock_gate_i(state.gate_sync),
    .d_i(ff_d),
    .q_o(ff_q)
  );

  // live status word
  always_comb
  begin
    status_word = '0;
    status_word[LC_STAT_FFX] = ff_q[0];
    status_word[LC_STAT_FFY] = ff_q[1];
    status_word[LC_STAT_CELLX] = state.cell_x;
    status_word[LC_STAT_CELLY] = state.cell_y;
    status_word[LC_STAT_IN_LSB +: LC_NUM_IN] = state.in_sync;
  end

  // request taken once, ack one cycle later
  always_comb
  begin
    bus_req = wb_cyc_i & wb_stb_i;
    bus_take = bus_req & ~state.ack;
  end

  // next state
  always_comb
  begin
    next_state = state;
    // two-stage synchronisers for pins
    next_state.in_meta = logic_in_i;
    next_state.in_sync = state.in_meta;
    next_state.din_meta = direct_data_i;
    next_state.din_sync = state.din_meta;
    next_state.gate_meta = ff_clock_gate_i;
    next_state.gate_sync = state.gate_meta;
    // registered cell outputs hide any multi-input decode hazard
    unique case (out_x_src)
      LC_OUT_FN_F: next_state.cell_x = fn_f;
      LC_OUT_FN_G: next_state.cell_x = fn_g;
      LC_OUT_FF_X: next_state.cell_x = ff_q[0];
      LC_OUT_FF_Y: next_state.cell_x = ff_q[1];
    endcase
    unique case (out_y_src)
      LC_OUT_FN_F: next_state.cell_y = fn_f;
      LC_OUT_FN_G: next_state.cell_y = fn_g;
      LC_OUT_FF_X: next_state.cell_y = ff_q[0];
      LC_OUT_FF_Y: next_state.cell_y = ff_q[1];
    endcase
    // bus answer
    next_state.ack = bus_take;
    next_state.rdata = '0;
    if (bus_take && !wb_we_i)
    begin
      unique case (wb_adr_i)
        LC_OFF_LUT_F: next_state.rdata[LC_LUT_BITS-1:0] = state.lut_f;
        LC_OFF_LUT_G: next_state.rdata[LC_LUT_BITS-1:0] = state.lut_g;
        LC_OFF_CTRL: next_state.rdata[LC_CTRL_BITS-1:0] = state.ctrl;
        LC_OFF_STATUS: next_state.rdata = status_word;
        default: next_state.rdata = '0;
      endcase
    end
    // configuration writes: besides the bus reset, the only way table contents change
    if (bus_take && wb_we_i)
    begin
      unique case (wb_adr_i)
        LC_OFF_LUT_F:
        begin
          next_state.lut_f = LC_LUT_BITS'(lc_merge({16'h0000, state.lut_f}, wb_dat_i,
                                      wb_sel_i));
        end
        LC_OFF_LUT_G:
        begin
          next_state.lut_g = LC_LUT_BITS'(lc_merge({16'h0000, state.lut_g}, wb_dat_i,
                                      wb_sel_i));
        end
        LC_OFF_CTRL:
        begin
          next_state.ctrl = LC_CTRL_BITS'(lc_merge({16'h0000, state.ctrl}, wb_dat_i,
                                     wb_sel_i));
        end
        default:
        begin
          next_state.ctrl = state.ctrl;
        end
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state.in_meta <= '0;
      state.in_sync <= '0;
      state.din_meta <= 1'b0;
      state.din_sync <= 1'b0;
      state.gate_meta <= 1'b0;
      state.gate_sync <= 1'b0;
      state.lut_f <= LC_LUT_RST;
      state.lut_g <= LC_LUT_RST;
      state.ctrl <= LC_CTRL_RST;
      state.ack <= 1'b0;
      state.rdata <= '0;
      state.cell_x <= 1'b0;
      state.cell_y <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_o = state.rdata;
  assign wb_ack_o = state.ack;
  assign cell_x_o = state.cell_x;
  assign cell_y_o = state.cell_y;
  assign first_ff_out_o = ff_q[0];
  assign second_ff_out_o = ff_q[1];

endmodule
`default_nettype wire

// ---- rtl/lc_lut4.sv ----
// one four-input look-up table
// assumes the table contents are static configuration
`timescale 1ns/1ps
`default_nettype none
module lc_lut4 #(
  parameter int SEL_W = 4
) (
  // configuration contents
  input wire logic [(1 << SEL_W)-1:0] table_i,
  // logic inputs acting as select lines
  input wire logic [SEL_W-1:0] sel_i,
  // selected bit
  output logic out_o
);

  // pure multiplexer from configuration bits
  always_comb
  begin
    out_o = table_i[sel_i];
  end

endmodule
`default_nettype wire

// ---- testbench/lc_logic_cell_checker.sv ----
// port-level assertions for the logic cell
// assumes one clock clk_i and the synchronous bus reset rst_i
`timescale 1ns/1ps
`default_nettype none
module lc_logic_cell_checker
  import lc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lc_pkg::LC_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // flip-flop side
  input wire logic ff_clock_gate_i,
  input wire logic cell_clear_i,
  input wire logic first_ff_out_o,
  input wire logic second_ff_out_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // bus answer timing and data lanes
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");
  chk_dat_write: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == '0)
    else $error("read data not zero on write ack");
  chk_dat_high: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read lanes not zero");

  // shared clear and clock gate of both flip-flops
  chk_clear_low: assert property (cell_clear_i |-> !first_ff_out_o && !second_ff_out_o)
    else $error("flip-flops not low under clear");
  chk_gate_hold: assert property (!ff_clock_gate_i && $past(!ff_clock_gate_i)
    && $past(!ff_clock_gate_i, 2) |=> cell_clear_i
    || ($stable(first_ff_out_o) && $stable(second_ff_out_o)))
    else $error("flip-flop changed with gate low");
endmodule

bind lc_logic_cell lc_logic_cell_checker u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .ff_clock_gate_i(ff_clock_gate_i),
  .cell_clear_i(cell_clear_i),
  .first_ff_out_o(first_ff_out_o),
  .second_ff_out_o(second_ff_out_o)
);
`default_nettype wire

// ---- testbench/lc_logic_cell_test.sv ----
// self-checking bench for the logic cell
// assumes the cell and its checker are compiled before this file
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module lc_logic_cell_test;
  import lc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [LC_ADR_W-1:0] wb_adr_i = '0;
  logic [LC_SEL_W-1:0] wb_sel_i = '0;
  logic [LC_DAT_W-1:0] wb_dat_i = '0;
  logic [LC_DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic [LC_NUM_IN-1:0] logic_in_i = '0;
  logic direct_data_i = 1'b0;
  logic ff_clock_gate_i = 1'b0;
  logic cell_clear_i = 1'b1;
  logic cell_x_o;
  logic cell_y_o;
  logic first_ff_out_o;
  logic second_ff_out_o;
  logic [LC_DAT_W-1:0] rd;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  lc_logic_cell u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .logic_in_i(logic_in_i),
    .direct_data_i(direct_data_i), .ff_clock_gate_i(ff_clock_gate_i),
    .cell_clear_i(cell_clear_i), .cell_x_o(cell_x_o), .cell_y_o(cell_y_o),
    .first_ff_out_o(first_ff_out_o), .second_ff_out_o(second_ff_out_o)
  );

  // 100 MHz clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // hang guard
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [LC_ADR_W-1:0] adr,
    input logic [LC_DAT_W-1:0] dat, input logic [LC_SEL_W-1:0] sel);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // expected {fn g, fn f}; g uses e, f uses d in dual mode
  function automatic logic [1:0] exp_fn(input logic [1:0] md, input logic [4:0] v);
    logic [15:0] tf;
    logic [15:0] tg;
    tf = 16'h6A3C;
    tg = 16'hC5E1;
    if (md == 2'b01 || md == 2'b10)
      return {2{v[4] ? tg[v[3:0]] : tf[v[3:0]]}};
    return {tg[{v[4], v[2:0]}], tf[v[3:0]]};
  endfunction

  // reset value, byte lanes, unmapped place
  task automatic t_regs();
    wb_xfer(1'b0, LC_OFF_CTRL, '0, 4'hF);
    `CHK(rd, 32'h0000_0000)
    wb_xfer(1'b1, LC_OFF_LUT_F, 32'hFFFF_ABCD, 4'h1);
    wb_xfer(1'b0, LC_OFF_LUT_F, '0, 4'hF);
    `CHK(rd, 32'h0000_00CD)
    wb_xfer(1'b1, 4'h2, 32'h0000_FFFF, 4'hF);
    wb_xfer(1'b0, 4'h2, '0, 4'hF);
    `CHK(rd, 32'h0000_0000)
  endtask

  // every mode code over all 32 input values
  task automatic t_modes();
    logic [1:0] e;
    wb_xfer(1'b1, LC_OFF_LUT_F, 32'h0000_6A3C, 4'hF);
    wb_xfer(1'b1, LC_OFF_LUT_G, 32'h0000_C5E1, 4'hF);
    for (int m = 0; m < 4; m++)
    begin
      wb_xfer(1'b1, LC_OFF_CTRL, 32'h0000_0408 | 32'(m), 4'hF);
      for (int v = 0; v < 32; v++)
      begin
        @(posedge clk_i);
        logic_in_i <= 5'(v);
        repeat (4) @(posedge clk_i);
        #1;
        e = exp_fn(2'(m), 5'(v));
        `CHK(cell_x_o, e[0])
        `CHK(cell_y_o, e[1])
      end
    end
  endtask

  // clear beats gate, load, hold with gate low
  task automatic t_flops();
    @(posedge clk_i);
    logic_in_i <= '0;
    wb_xfer(1'b1, LC_OFF_CTRL, 32'h0000_AE00, 4'hF);
    @(posedge clk_i);
    cell_clear_i <= 1'b1;
    direct_data_i <= 1'b1;
    ff_clock_gate_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    `CHK({first_ff_out_o, second_ff_out_o}, 2'b00)
    @(posedge clk_i);
    cell_clear_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK({first_ff_out_o, second_ff_out_o, cell_x_o, cell_y_o}, 4'hF)
    @(posedge clk_i);
    ff_clock_gate_i <= 1'b0;
    @(posedge clk_i);
    direct_data_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    `CHK({first_ff_out_o, second_ff_out_o, cell_x_o, cell_y_o}, 4'hF)
    wb_xfer(1'b0, LC_OFF_STATUS, '0, 4'hF);
    `CHK(rd, 32'h0000_000F)
  endtask

  // first flip-flop replaces b, dual then merged
  task automatic t_feedback();
    wb_xfer(1'b1, LC_OFF_LUT_F, 32'h0000_0008, 4'hF);
    wb_xfer(1'b1, LC_OFF_LUT_G, 32'h0000_0008, 4'hF);
    for (int k = 0; k < 2; k++)
    begin
      wb_xfer(1'b1, LC_OFF_CTRL, 32'h0000_2410 | 32'(k), 4'hF);
      @(posedge clk_i);
      logic_in_i <= (k == 1) ? 5'b10001 : 5'b00001;
      direct_data_i <= 1'b1;
      ff_clock_gate_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      ff_clock_gate_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      `CHK({first_ff_out_o, cell_x_o}, 2'b11)
      `CHK(cell_y_o, 1'(k))
      @(posedge clk_i);
      cell_clear_i <= 1'b1;
      @(posedge clk_i);
      cell_clear_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      `CHK({first_ff_out_o, cell_x_o}, 2'b00)
    end
  endtask

  // bus reset in mid-run returns the control register to its reset value
  task automatic t_rerun();
    wb_xfer(1'b1, LC_OFF_CTRL, 32'h0000_1234, 4'hF);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, LC_OFF_CTRL, '0, 4'hF);
    `CHK(rd, 32'h0000_0000)
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    cell_clear_i <= 1'b0;
    t_regs();
    t_modes();
    t_flops();
    t_feedback();
    t_rerun();
    close_out();
  end
endmodule
`default_nettype wire
